// file: panel_defs.svh
// Purpose: Constants of the front-panel sequencer
// Assumes: 200 MHz core clock
// Notes: Offsets are byte addresses on the register bus
`ifndef PANEL_DEFS_SVH
`define PANEL_DEFS_SVH
`define CLK_PERIOD_NS 5
`define DEBOUNCE_NS 1000000
`define PD_TIMEOUT_NS 5000000
`define REG_SWITCH 4'h0
`define REG_STATUS 4'h4
`define REG_CTRL 4'h8
`define CTRL_POW_BIT 0
`define CTRL_RESET 1'h0
`define BOOT_BASE 14'h0100
`define BOOT_LEN 9'h100
`define ON_START_REDUCED 14'h017C
`define ON_START_STD 14'h0000
`endif

// file: panel_pkg.sv
// Purpose: Types shared by the front-panel sequencer
// Assumes: Nothing
// Notes: Constants live in panel_defs.svh
package panel_pkg;
    typedef enum logic [1:0] {KEY_OFF = 2'h0, KEY_ON = 2'h1, KEY_LOCK = 2'h2, KEY_AUTO = 2'h3} key_t;
    typedef enum logic [2:0] {S_OFF, S_RUN, S_STOPPED, S_STEP, S_MEM, S_BOOT, S_BOOTWR, S_PWRDN} seq_state_t;
    typedef struct packed {
        logic halt;
        logic perform;
        logic addrLoad;
        logic store;
        logic fetch;
        logic [13:0] data;
    } switches_t;
    typedef struct packed {
        logic [7:0] acc;
        logic [13:0] loc;
        logic enable;
        logic carry;
        logic waitMode;
        logic power;
    } lamps_t;
endpackage : panel_pkg

// file: front_panel_control_sequencer.sv
// Purpose: Front-panel sequencer acting on operator switches for the processor
// Assumes: Core halts at instruction boundaries while run is low; memory port answers with memAck
// Notes: Switch pins are synchronised; perform is debounced
// Behaviour
// - Halt latched plus perform press stops execution at next instruction.
// - Stopped with address-load, perform copies fourteen data switches into location counter.
// - Stopped with switches released, perform starts execution at location counter.
// - Stopped with halt only, each perform runs exactly one instruction.
// - While stepping, pending interrupt is taken on perform; next press runs table.
// - Fetch switch: perform reads byte at location into accumulator, increments location.
// - Store switch: perform writes switches 08:15 at location, shows it, increments.
// - From wait, halt plus perform then release plus perform resumes after wait.
// - Reading switch register returns data switches 08:15 to software.
// - Reduced panel, key off to auto loads 256 serial bytes from 0x100.
// - After auto-load, execution begins at 0x100.
// - Reduced panel, key off to on starts execution at 0x017C.
// - Power-down completes on its own after a timeout without program action.
// - Panel switches are ignored unless key is in on position.
// - Selected function acts only when perform is pressed.
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "panel_defs.svh"
module front_panel_control_sequencer #(
    parameter int DebounceCyc = `DEBOUNCE_NS / `CLK_PERIOD_NS,
    parameter int PdTimeoutCyc = `PD_TIMEOUT_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Panel switches and key
    input wire panel_pkg::switches_t switchPins,
    input wire logic [1:0] keyPins,
    input wire logic reducedPanel,
    // Indicator lamps
    output panel_pkg::lamps_t lamps,
    // Processor state and control
    input wire logic [13:0] coreLoc,
    input wire logic [7:0] coreAcc,
    input wire logic coreCarry,
    input wire logic coreEnable,
    input wire logic coreWaiting,
    input wire logic intPending,
    input wire logic stepDone,
    output logic runCore,
    output logic stepReq,
    output logic intTake,
    output logic clearWait,
    output logic locLoad,
    output logic [13:0] locLoadVal,
    output logic accLoad,
    output logic [7:0] accLoadVal,
    output logic powerFail,
    output logic powerDown,
    // Memory port
    output logic memReq,
    output logic memWe,
    output logic [13:0] memAddr,
    output logic [7:0] memWdata,
    input wire logic [7:0] memRdata,
    input wire logic memAck,
    // Serial loader input
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    // Avalon-MM slave
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest
);
    import panel_pkg::*;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    switches_t swMeta_r, sw_r;
    logic [1:0] keyMeta_r, key_r;
    logic perfStable_r, perfPrev_r, perfEdge;
    logic [19:0] dbCnt_r;
    logic [19:0] pdCnt_r;
    seq_state_t state_r;
    logic memPanelWr_r;
    logic [8:0] bootCnt_r;
    logic powCmd_r;
    logic avAck_r;
    logic keyOn, fnSel;

    // Increment of a 14-bit address
    function automatic logic [13:0] incAddr(input logic [13:0] a);
        incAddr = a + 14'h0001;
    endfunction : incAddr

    // Two-stage synchronisers for every switch and key pin; reducedPanel is used unsynchronised
    always_ff @(posedge core_clk)
    begin
        swMeta_r <= switchPins;
        sw_r <= swMeta_r;
        keyMeta_r <= keyPins;
        key_r <= keyMeta_r;
    end

    // Debounce of perform: accept a level held stable for the full count
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            perfStable_r <= 1'b0;
            dbCnt_r <= 20'h00000;
            perfPrev_r <= 1'b0;
        end
        else
        begin
            perfPrev_r <= perfStable_r;
            if (sw_r.perform == perfStable_r)
                dbCnt_r <= 20'h00000;
            else if (dbCnt_r >= 20'(DebounceCyc - 1))
            begin
                perfStable_r <= sw_r.perform;
                dbCnt_r <= 20'h00000;
            end
            else
                dbCnt_r <= dbCnt_r + 20'h00001;
        end
    end

    // One pulse per accepted press in any key position; key on is decoded beside it
    assign perfEdge = perfStable_r && !perfPrev_r;
    assign keyOn = (key_t'(key_r) == KEY_ON);
    assign fnSel = sw_r.addrLoad || sw_r.store || sw_r.fetch;

    // Lamps mirror processor state
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            lamps <= '0;
        else
        begin
            lamps.acc <= coreAcc;
            lamps.loc <= coreLoc;
            lamps.enable <= coreEnable;
            lamps.carry <= coreCarry;
            lamps.waitMode <= coreWaiting;
            lamps.power <= (state_r != S_OFF);
        end
    end

    // Main panel sequencer
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_r <= S_OFF;
            runCore <= 1'b0;
            stepReq <= 1'b0;
            intTake <= 1'b0;
            clearWait <= 1'b0;
            locLoad <= 1'b0;
            locLoadVal <= 14'h0000;
            accLoad <= 1'b0;
            accLoadVal <= 8'h00;
            powerFail <= 1'b0;
            memReq <= 1'b0;
            memWe <= 1'b0;
            memAddr <= 14'h0000;
            memWdata <= 8'h00;
            memPanelWr_r <= 1'b0;
            bootCnt_r <= 9'h000;
            pdCnt_r <= 20'h00000;
        end
        else
        begin
            stepReq <= 1'b0;
            intTake <= 1'b0;
            clearWait <= 1'b0;
            locLoad <= 1'b0;
            accLoad <= 1'b0;
            powerFail <= 1'b0;
            if (key_t'(key_r) == KEY_OFF && state_r != S_OFF && state_r != S_PWRDN)
            begin
                // Key off raises the power-fail interrupt and starts the timeout
                powerFail <= 1'b1;
                pdCnt_r <= 20'h00000;
                memReq <= 1'b0;
                state_r <= S_PWRDN;
            end
            else
            begin
                unique case (state_r)
                    S_OFF:
                    begin
                        bootCnt_r <= 9'h000;
                        if (key_t'(key_r) == KEY_ON)
                        begin
                            locLoad <= 1'b1;
                            locLoadVal <= reducedPanel ? `ON_START_REDUCED : `ON_START_STD;
                            runCore <= 1'b1;
                            state_r <= S_RUN;
                        end
                        else if (key_t'(key_r) == KEY_AUTO && reducedPanel)
                            state_r <= S_BOOT;
                    end
                    S_RUN:
                        if (perfEdge && keyOn && sw_r.halt)
                        begin
                            runCore <= 1'b0;
                            state_r <= S_STOPPED;
                        end
                    S_STOPPED:
                        if (perfEdge && keyOn)
                        begin
                            if (sw_r.addrLoad)
                            begin
                                locLoad <= 1'b1;
                                locLoadVal <= sw_r.data;
                            end
                            else if (sw_r.fetch || sw_r.store)
                            begin
                                memReq <= 1'b1;
                                memWe <= sw_r.store;
                                memPanelWr_r <= sw_r.store;
                                memAddr <= coreLoc;
                                memWdata <= sw_r.data[7:0];
                                state_r <= S_MEM;
                            end
                            else if (sw_r.halt && intPending)
                                intTake <= 1'b1;
                            else if (sw_r.halt)
                            begin
                                stepReq <= 1'b1;
                                state_r <= S_STEP;
                            end
                            else
                            begin
                                runCore <= 1'b1;
                                clearWait <= coreWaiting;
                                state_r <= S_RUN;
                            end
                        end
                    S_STEP:
                        if (stepDone)
                            state_r <= S_STOPPED;
                    S_MEM:
                        if (memAck)
                        begin
                            memReq <= 1'b0;
                            accLoad <= 1'b1;
                            accLoadVal <= memPanelWr_r ? memWdata : memRdata;
                            locLoad <= 1'b1;
                            locLoadVal <= incAddr(memAddr);
                            state_r <= S_STOPPED;
                        end
                    S_BOOT:
                        if (rxValid)
                        begin
                            memReq <= 1'b1;
                            memWe <= 1'b1;
                            memAddr <= `BOOT_BASE + 14'(bootCnt_r);
                            memWdata <= rxData;
                            state_r <= S_BOOTWR;
                        end
                    S_BOOTWR:
                        if (memAck)
                        begin
                            memReq <= 1'b0;
                            bootCnt_r <= bootCnt_r + 9'h001;
                            if (bootCnt_r == `BOOT_LEN - 9'h001)
                            begin
                                locLoad <= 1'b1;
                                locLoadVal <= `BOOT_BASE;
                                runCore <= 1'b1;
                                state_r <= S_RUN;
                            end
                            else
                                state_r <= S_BOOT;
                        end
                    S_PWRDN:
                    begin
                        pdCnt_r <= pdCnt_r + 20'h00001;
                        if (powCmd_r || pdCnt_r >= 20'(PdTimeoutCyc - 1))
                        begin
                            runCore <= 1'b0;
                            state_r <= S_OFF;
                        end
                    end
                endcase
            end
        end
    end

    assign powerDown = (state_r == S_OFF);

    // Avalon handshake: one wait cycle, then the answer
    assign avsWaitrequest = (avsRead || avsWrite) && !avAck_r;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            avAck_r <= 1'b0;
        else
            avAck_r <= (avsRead || avsWrite) && !avAck_r;
    end

    // Control register; power-down command taken at the accepting edge
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            powCmd_r <= `CTRL_RESET;
        else if (avsWrite && avAck_r && avsAddress == `REG_CTRL)
            powCmd_r <= avsWritedata[`CTRL_POW_BIT];
        else if (state_r == S_OFF)
            powCmd_r <= 1'b0;
    end

    // Read data prepared during the wait cycle
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            avsReaddata <= 32'h00000000;
        else if (avsRead && !avAck_r)
        begin
            unique case (avsAddress)
                `REG_SWITCH: avsReaddata <= {24'h000000, sw_r.data[7:0]};
                `REG_STATUS: avsReaddata <= {25'h0000000, key_r, powerDown, runCore, state_r};
                `REG_CTRL: avsReaddata <= {31'h00000000, powCmd_r};
                default: avsReaddata <= 32'h00000000;
            endcase
        end
    end

    sequence s_press_stopped;
        state_r == S_STOPPED && perfEdge && keyOn;
    endsequence

    sequence s_mem_done;
        state_r == S_MEM && memAck && key_t'(key_r) != KEY_OFF;
    endsequence

    a_halt_stops: assert property ((state_r == S_RUN && perfEdge && keyOn && sw_r.halt)
        |=> !runCore && state_r == S_STOPPED) else $error("halt press did not stop");
    a_addr_load: assert property (s_press_stopped ##0 sw_r.addrLoad
        |=> locLoad && locLoadVal == $past(sw_r.data)) else $error("address load wrong");
    a_start_run: assert property (s_press_stopped ##0 !sw_r.halt && !fnSel
        |=> runCore ##1 runCore) else $error("start did not run");
    a_single_step: assert property (s_press_stopped ##0 sw_r.halt && !fnSel && !intPending
        |=> stepReq ##1 !stepReq) else $error("step pulse wrong");
    a_int_take: assert property (s_press_stopped ##0 sw_r.halt && !fnSel && intPending
        |=> intTake && !stepReq) else $error("interrupt not taken");
    a_mem_incr: assert property (s_mem_done
        |=> locLoad && accLoad && locLoadVal == $past(memAddr) + 14'h0001) else $error("increment wrong");
    a_store_data: assert property (s_press_stopped ##0 sw_r.store && !sw_r.addrLoad
        |=> memReq && memWe && memWdata == $past(sw_r.data[7:0])) else $error("store data wrong");
    a_boot_addr: assert property ((state_r == S_BOOT && rxValid && key_t'(key_r) != KEY_OFF)
        |=> memAddr == `BOOT_BASE + 14'($past(bootCnt_r))) else $error("boot address wrong");
    a_boot_start: assert property ((state_r == S_BOOTWR && memAck && bootCnt_r == 9'h0FF
        && key_t'(key_r) != KEY_OFF)
        |=> locLoad && locLoadVal == `BOOT_BASE && runCore) else $error("boot start wrong");
    a_reduced_on: assert property ((state_r == S_OFF && keyOn && reducedPanel)
        |=> locLoadVal == `ON_START_REDUCED) else $error("power-on start wrong");
    a_pd_timeout: assert property ((state_r == S_PWRDN && pdCnt_r == 20'(PdTimeoutCyc - 1))
        |=> powerDown) else $error("power-down not forced");
    a_lock_ignore: assert property ((state_r == S_STOPPED && !keyOn)
        |=> state_r != S_MEM && state_r != S_STEP && !locLoad) else $error("locked panel acted");
    a_press_once: assert property (perfEdge |=> !perfEdge [*7]) else $error("press gave two pulses");
endmodule : front_panel_control_sequencer
`default_nettype wire

// file: panel_operator.sv
// Purpose: Operator model driving panel switches and key
// Assumes: Switches latch; perform is momentary and bounces when pressed
// Notes: The bench reads the lamps through this model
`timescale 1ns/1ps
`default_nettype none
module panel_operator (
    // Clock
    input wire logic core_clk,
    // Switches and key
    output panel_pkg::switches_t switchPins,
    output logic [1:0] keyPins,
    // Lamps being watched
    input wire panel_pkg::lamps_t lamps
);
    import panel_pkg::*;
    // Power off, every switch up
    initial
    begin
        switchPins = '0;
        keyPins = KEY_OFF;
    end
    // Turn the key, then give the synchroniser time
    task setKey(input key_t k);
        @(posedge core_clk);
        keyPins <= k;
        repeat (12) @(posedge core_clk);
    endtask : setKey
    // Latch switches; a second function switch is never raised with the first
    task setPanel(input logic h, input logic a, input logic s, input logic f, input logic [13:0] d);
        @(posedge core_clk);
        switchPins.halt <= h;
        switchPins.addrLoad <= a;
        switchPins.store <= s & ~a;
        switchPins.fetch <= f & ~a & ~s;
        switchPins.data <= d;
        repeat (4) @(posedge core_clk);
    endtask : setPanel
    // Momentary press with contact bounce on the way down
    task press();
        @(posedge core_clk);
        switchPins.perform <= 1'b1;
        repeat (2) @(posedge core_clk);
        switchPins.perform <= 1'b0;
        @(posedge core_clk);
        switchPins.perform <= 1'b1;
        repeat (14) @(posedge core_clk);
        switchPins.perform <= 1'b0;
        repeat (14) @(posedge core_clk);
    endtask : press
    // Single step: function switches dropped first, halt kept down
    task step();
        setPanel(1'b1, 1'b0, 1'b0, 1'b0, switchPins.data);
        press();
    endtask : step
endmodule : panel_operator
`default_nettype wire

// file: front_panel_control_sequencer_test.sv
// Purpose: Self-checking bench for the front-panel sequencer
// Assumes: Short debounce and power-down counts for simulation
// Notes: Core and memory are small behavioural models in this file
`timescale 1ns/1ps
`default_nettype none
module front_panel_control_sequencer_test;
    import panel_pkg::*;
    logic core_clk, rst_n, reducedPanel, coreWaiting, intPending, memAck, rxValid;
    logic coreCarry, coreEnable, stepDone;
    switches_t switchPins;
    logic [1:0] keyPins;
    lamps_t lamps;
    logic [13:0] coreLoc = 14'h3FFF;
    logic [13:0] locLoadVal, memAddr, lastWr;
    logic [7:0] coreAcc = 8'h00;
    logic [7:0] accLoadVal, memWdata, memRdata, rxData, lastWd;
    logic runCore, stepReq, intTake, clearWait, locLoad, accLoad, powerFail, powerDown, memReq, memWe;
    logic [3:0] avsAddress;
    logic avsRead, avsWrite, avsWaitrequest;
    logic [31:0] avsWritedata, avsReaddata, q;
    int failCount = 0;
    int nChecks = 0;
    int nWr = 0;
    int nStep = 0;
    int nInt = 0;
    int nWake = 0;
    int nFail = 0;
    int nLoc = 0;
    int base;
    panel_operator op (.core_clk(core_clk), .switchPins(switchPins), .keyPins(keyPins), .lamps(lamps));
    front_panel_control_sequencer #(.DebounceCyc(4), .PdTimeoutCyc(20)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .switchPins(switchPins), .keyPins(keyPins), .reducedPanel(reducedPanel), .lamps(lamps),
        .coreLoc(coreLoc), .coreAcc(coreAcc), .coreCarry(coreCarry), .coreEnable(coreEnable),
        .coreWaiting(coreWaiting), .intPending(intPending), .stepDone(stepDone), .runCore(runCore),
        .stepReq(stepReq), .intTake(intTake), .clearWait(clearWait), .locLoad(locLoad), .locLoadVal(locLoadVal),
        .accLoad(accLoad), .accLoadVal(accLoadVal), .powerFail(powerFail), .powerDown(powerDown),
        .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
        .memAck(memAck), .rxValid(rxValid), .rxData(rxData), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest));
    // Clock at 200 MHz
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Memory reads back a pattern of its address
    assign memRdata = memAddr[7:0] ^ 8'hA5;
    // Core and memory: answer one cycle late, count writes and the location, step, interrupt, wake and power-fail pulses
    always @(posedge core_clk)
    begin
        stepDone <= stepReq;
        memAck <= memReq & ~memAck;
        coreLoc <= locLoad ? locLoadVal : (stepDone ? coreLoc + 14'h0001 : coreLoc);
        if (accLoad)
            coreAcc <= accLoadVal;
        if (memReq && memAck && memWe)
        begin
            nWr <= nWr + 1;
            lastWr <= memAddr;
            lastWd <= memWdata;
        end
        nLoc <= nLoc + int'(locLoad);
        nStep <= nStep + int'(stepReq);
        nInt <= nInt + int'(intTake);
        nWake <= nWake + int'(clearWait);
        nFail <= nFail + int'(powerFail);
    end
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    // Compare and count; a mismatch is reported at once
    task check(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            $display("wrong value at %0d ns: got %h expected %h", $time, got, exp);
            failCount++;
        end
    endtask : check
    // One bus cycle, held until waitrequest is seen low
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= ~wr;
        avsWritedata <= d;
        do
        begin
            @(posedge core_clk);
        end while (avsWaitrequest !== 1'b0);
        r = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task testStopLoad();
        op.setKey(KEY_ON);
        check(coreLoc, 14'h0000);
        op.setKey(KEY_LOCK);
        op.setPanel(1'b1, 1'b0, 1'b0, 1'b0, 14'h0000);
        op.press();
        check(runCore, 1'b1);
        op.setKey(KEY_ON);
        check(runCore, 1'b1);
        op.press();
        check(runCore, 1'b0);
        op.setPanel(1'b1, 1'b1, 1'b0, 1'b0, 14'h2A7C);
        check(coreLoc, 14'h0000);
        base = nLoc;
        op.press();
        check(coreLoc, 14'h2A7C);
        check(op.lamps.loc, 14'h2A7C);
        check(nLoc - base, 1);
        $display("stop and load test done");
    endtask : testStopLoad
    task testMemory();
        op.setPanel(1'b1, 1'b0, 1'b0, 1'b1, 14'h2A7C);
        op.press();
        check(coreAcc, 8'hD9);
        check(coreLoc, 14'h2A7D);
        check(op.lamps.acc, 8'hD9);
        op.setPanel(1'b1, 1'b0, 1'b1, 1'b0, 14'h005C);
        op.press();
        check({lastWr, lastWd, coreAcc}, {14'h2A7D, 8'h5C, 8'h5C});
        check(coreLoc, 14'h2A7E);
        bus(1'b0, 4'h0, 32'h0, q);
        check(q[7:0], 8'h5C);
        bus(1'b1, 4'hC, 32'hFFFFFFFF, q);
        bus(1'b0, 4'hC, 32'h0, q);
        check(q, 32'h0);
        $display("memory test done");
    endtask : testMemory
    task testStep();
        op.setPanel(1'b1, 1'b1, 1'b0, 1'b0, 14'h0040);
        op.press();
        base = nStep;
        op.step();
        check(coreLoc, 14'h0041);
        check(nStep - base, 1);
        op.setKey(KEY_LOCK);
        op.step();
        check(nStep - base, 1);
        op.setKey(KEY_ON);
        intPending <= 1'b1;
        op.step();
        check(nInt, 1);
        check(nStep - base, 1);
        intPending <= 1'b0;
        op.step();
        check(nStep - base, 2);
        check(runCore, 1'b0);
        $display("step test done");
    endtask : testStep
    task testResume();
        op.setPanel(1'b0, 1'b0, 1'b0, 1'b0, 14'h0000);
        op.press();
        check(runCore, 1'b1);
        check(coreLoc, 14'h0042);
        coreWaiting <= 1'b1;
        {coreCarry, coreEnable} <= 2'h3;
        op.setPanel(1'b1, 1'b0, 1'b0, 1'b0, 14'h0000);
        op.press();
        check(runCore, 1'b0);
        check({op.lamps.enable, op.lamps.carry, op.lamps.waitMode, op.lamps.power}, 4'hF);
        op.setPanel(1'b0, 1'b0, 1'b0, 1'b0, 14'h0000);
        op.press();
        check(nWake, 1);
        check(runCore, 1'b1);
        coreWaiting <= 1'b0;
        $display("resume test done");
    endtask : testResume
    task testPower();
        op.setKey(KEY_OFF);
        check(nFail, 1);
        bus(1'b1, 4'h8, 32'h1, q);
        tick(4);
        bus(1'b0, 4'h4, 32'h0, q);
        check(q[6:0], 7'h10);
        op.setKey(KEY_ON);
        check(runCore, 1'b1);
        op.setKey(KEY_OFF);
        tick(40);
        check({powerDown, runCore}, 2'h2);
        $display("power test done");
    endtask : testPower
    task testReduced();
        reducedPanel <= 1'b1;
        op.setKey(KEY_ON);
        check(coreLoc, 14'h017C);
        op.setKey(KEY_OFF);
        tick(40);
        base = nWr;
        op.setKey(KEY_AUTO);
        for (int i = 0; i < 256; i++)
        begin
            rxValid <= 1'b1;
            rxData <= i[7:0];
            @(posedge core_clk);
            rxValid <= 1'b0;
            tick(7);
        end
        check(nWr - base, 256);
        check({lastWr, lastWd}, {14'h01FF, 8'hFF});
        for (int n = 0; n < 200 && runCore !== 1'b1; n++)
            @(posedge core_clk);
        tick(4);
        check({runCore, coreLoc}, {1'b1, 14'h0100});
        $display("reduced panel test done");
    endtask : testReduced
    task completeRun();
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : completeRun
    // Watchdog for a hung handshake
    initial
    begin
        #200000;
        failCount++;
        completeRun();
    end
    // Main sequence
    initial
    begin
        {rst_n, reducedPanel, coreWaiting, intPending, rxValid, rxData, coreCarry, coreEnable} = '0;
        {avsAddress, avsRead, avsWrite, avsWritedata} = '0;
        tick(12);
        rst_n <= 1'b1;
        @(posedge core_clk);
        check(powerDown, 1'b1);
        testStopLoad();
        testMemory();
        testStep();
        testResume();
        testPower();
        testReduced();
        completeRun();
    end
endmodule : front_panel_control_sequencer_test
`default_nettype wire
